// >>> design/adm_pkg.sv
/*
 Shared constants and types of the analog die mode controller and its
 companion microcontroller end. Assumes one 100 MHz clock for both ends.
*/
package adm_pkg;
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_STOP   = 2'h1;
	localparam logic [1:0] MODE_SLEEP  = 2'h2;
	localparam logic [1:0] MODE_UNUSED = 2'h3;

	// Power status register layout: high byte reset cause, low byte wake source
	localparam int         CAUSE_LSB   = 8;
	localparam int         WAKE_LSB    = 0;
	localparam logic [7:0] CAUSE_NONE  = 8'h00;
	localparam logic [7:0] CAUSE_POR   = 8'h01;
	localparam logic [7:0] CAUSE_EXT   = 8'h02;
	localparam logic [7:0] WAKE_NONE   = 8'h00;
	localparam logic [7:0] WAKE_UV     = 8'h01;
	localparam logic [7:0] WAKE_LTC    = 8'h02;
	localparam logic [7:0] WAKE_EXT    = 8'h04;

	localparam int         LTC_WIDTH   = 16;
	localparam logic [15:0] LTC_MAX    = 16'hffff;
	localparam logic [15:0] LTC_ONE    = 16'h0001;
	localparam logic [15:0] LTC_ZERO   = 16'h0000;
	localparam logic [15:0] STAT_ZERO  = 16'h0000;

	// AXI4-Lite register map of the microcontroller end
	localparam logic [3:0] REG_CTRL    = 4'h0;
	localparam logic [3:0] REG_STATUS  = 4'h4;
	localparam logic [3:0] REG_WAKECLR = 4'h8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_RESET, ST_NORMAL, ST_STOP_WAIT, ST_STOP, ST_SLEEP, ST_RECOVER, ST_INTER
	} adm_state_t;
endpackage : adm_pkg

// >>> design/adm_link_if.sv
/*
 Die-to-die link between the analog die mode controller and the
 microcontroller end. Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface adm_link_if (input wire logic clk);
	logic        modeWrite;
	logic [1:0]  modeData;
	logic        wakeClear;
	logic        mcuStopped;
	logic [15:0] powerStatus;
	logic        resetOutN;
	logic        wakeIrq;
	logic        lowPower;
	logic        intermediate;

	modport analog (input modeWrite, modeData, wakeClear, mcuStopped,
		output powerStatus, resetOutN, wakeIrq, lowPower, intermediate);
	modport mcu (output modeWrite, modeData, wakeClear, mcuStopped,
		input powerStatus, resetOutN, wakeIrq, lowPower, intermediate);
endinterface : adm_link_if
`default_nettype wire

// >>> design/adm_analog_die.sv
/*
 Analog die mode controller: Normal, Stop, Sleep, Intermediate and Reset
 states, rail gating, reset output and wake interrupt.
 Assumes supply monitor levels and wake events are synchronous to clk.
*/
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Mode 10 enters Sleep, wake sources armed
// - Mode 01 enters Stop after clock stops
// - Microcontroller writes 00 for Normal mode
// - Low-power exits pass through Intermediate state
// - Intermediate accepts Stop or Sleep directly
// - Reset condition: reset low, defaults restored
// - Last reset cause in status high byte
// - Permanent supply low means power-on reset
// - Sleep wake releases reset after regulators
// - Stop wake restores supply, raises interrupt
// - Every wake flags its source
// - Interface and timer read-only until Normal; the interface only from a Stop write, not after Sleep entered from Normal
// - Wake reinitialises the window watchdog
// - Watchdog on oscillator clock, off in low-power
// - Microcontroller clears wake flag before re-entry
// - Microcontroller services interrupts before mode write
// - Undervoltage interrupt, cranking selects lower threshold
// - Lifetime counter runs, overflow wakes
// - Counter locked in Intermediate, restarts from zero
// - Microcontroller waits for PLL lock
// - Low-power: acquisition clocked from oscillator
// - Stop drops interface rail; Sleep both
// - Cranking return looks like undervoltage wake
module adm_analog_die
	import adm_pkg::*;
(
	input  wire logic    clk,
	input  wire logic    reset,
	// Link
	adm_link_if.analog   link,
	// Supply monitors and wake events
	input  wire logic    permSupplyLow,
	input  wire logic    extResetReq,
	input  wire logic    supplyBelowLow,
	input  wire logic    supplyBelowCrank,
	input  wire logic    crankingEnable,
	input  wire logic    regulatorsGood,
	input  wire logic    extWake,
	input  wire logic    crankReturn,
	input  wire logic    ltcTick,
	// Power and clock control
	output logic         mcuSupplyRail,
	output logic         mcuSupplyMain,
	output logic         interfaceSupplyRail,
	output logic         useLowpowerClock,
	output logic         watchdogEnable,
	output logic         watchdogInit,
	output logic         regsReadOnly,
	output logic         ltcAccessible,
	output logic         undervoltageIrq,
	output logic         lowvoltResetFlag,
	output logic [15:0]  lifetimeCount
);
	adm_state_t  state;
	adm_state_t  next_state;
	logic        fromStop;
	logic [7:0]  resetCause;
	logic [7:0]  wakeSource;
	logic        uvBelow;
	logic        uvPrev;
	logic        wakeEvent;
	logic [7:0]  next_wake;
	logic        anyReset;
	logic        ltcOverflow;

	assign anyReset    = reset || permSupplyLow || extResetReq;
	assign ltcOverflow = ltcTick && (lifetimeCount == LTC_MAX);
	assign uvBelow     = crankingEnable ? supplyBelowCrank : supplyBelowLow;

	always_comb begin
		next_wake = WAKE_NONE;
		if (crankReturn || uvBelow)
			next_wake = next_wake | WAKE_UV;
		if (ltcOverflow)
			next_wake = next_wake | WAKE_LTC;
		if (extWake)
			next_wake = next_wake | WAKE_EXT;
	end
	assign wakeEvent = next_wake != WAKE_NONE;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_RESET:     next_state = ST_NORMAL;
			ST_NORMAL, ST_INTER: begin
				if (link.modeWrite && link.modeData == MODE_SLEEP)
					next_state = ST_SLEEP;
				else if (link.modeWrite && link.modeData == MODE_STOP)
					next_state = ST_STOP_WAIT;
				else if (link.modeWrite && link.modeData == MODE_NORMAL)
					next_state = ST_NORMAL;
			end
			ST_STOP_WAIT: if (link.mcuStopped)
				next_state = ST_STOP;
			ST_STOP, ST_SLEEP: if (wakeEvent)
				next_state = ST_RECOVER;
			ST_RECOVER: if (regulatorsGood)
				next_state = ST_INTER;
		endcase
	end

	always_ff @(posedge clk) begin
		if (anyReset)
			state <= ST_RESET;
		else
			state <= next_state;
	end

	always_ff @(posedge clk) begin
		if (anyReset)
			fromStop <= 1'b0;
		else if (state == ST_STOP)
			fromStop <= 1'b1;
		else if (state == ST_SLEEP)
			fromStop <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (permSupplyLow) begin
			resetCause       <= CAUSE_POR;
			lowvoltResetFlag <= 1'b1;
		end else if (extResetReq) begin
			resetCause <= CAUSE_EXT;
		end else if (reset) begin
			resetCause       <= CAUSE_NONE;
			lowvoltResetFlag <= 1'b0;
		end
	end

	// wake source, set wins over clear
	always_ff @(posedge clk) begin
		if (anyReset)
			wakeSource <= WAKE_NONE;
		else if ((state == ST_STOP || state == ST_SLEEP) && wakeEvent)
			wakeSource <= next_wake;
		else if (link.wakeClear)
			wakeSource <= WAKE_NONE;
	end

	always_ff @(posedge clk) begin
		if (anyReset)
			link.powerStatus <= STAT_ZERO;
		else
			link.powerStatus <= {resetCause, wakeSource};
	end

	always_ff @(posedge clk) begin
		if (anyReset)
			link.resetOutN <= 1'b0;
		else
			link.resetOutN <= !(state == ST_RESET || state == ST_SLEEP || next_state == ST_SLEEP
				|| (state == ST_RECOVER && !regulatorsGood && !fromStop));
	end

	always_ff @(posedge clk) begin
		if (anyReset)
			link.wakeIrq <= 1'b0;
		else
			link.wakeIrq <= state == ST_RECOVER && regulatorsGood && fromStop;
	end

	always_ff @(posedge clk) begin
		if (anyReset) begin
			mcuSupplyRail       <= 1'b1;
			mcuSupplyMain       <= 1'b1;
			interfaceSupplyRail <= 1'b1;
		end else begin
			mcuSupplyRail       <= !(next_state == ST_SLEEP || (next_state == ST_RECOVER && !fromStop
				&& state == ST_SLEEP));
			mcuSupplyMain       <= !(next_state == ST_STOP || next_state == ST_SLEEP);
			interfaceSupplyRail <= !(next_state == ST_STOP || next_state == ST_SLEEP);
		end
	end

	// clock held on oscillator until Normal
	always_ff @(posedge clk) begin
		if (anyReset) begin
			useLowpowerClock  <= 1'b0;
			link.lowPower     <= 1'b0;
			link.intermediate <= 1'b0;
		end else begin
			useLowpowerClock  <= next_state != ST_NORMAL && next_state != ST_RESET
				&& next_state != ST_STOP_WAIT;
			// Low power stands until the regulators are back
			link.lowPower     <= next_state == ST_STOP || next_state == ST_SLEEP || next_state == ST_RECOVER;
			link.intermediate <= next_state == ST_INTER;
		end
	end

	// watchdog in Normal and Intermediate; wake reinitialises
	always_ff @(posedge clk) begin
		if (anyReset) begin
			watchdogEnable <= 1'b0;
			watchdogInit   <= 1'b1;
		end else begin
			watchdogEnable <= next_state == ST_NORMAL || next_state == ST_INTER;
			watchdogInit   <= state == ST_RECOVER && regulatorsGood;
		end
	end

	// read-only from Stop write until Normal
	always_ff @(posedge clk) begin
		if (anyReset)
			regsReadOnly <= 1'b0;
		else if (next_state == ST_NORMAL)
			regsReadOnly <= 1'b0;
		else if (link.modeWrite && link.modeData == MODE_STOP)
			regsReadOnly <= 1'b1;
	end

	always_ff @(posedge clk) begin
		if (anyReset)
			ltcAccessible <= 1'b0;
		else
			ltcAccessible <= next_state == ST_NORMAL;
	end

	// counter runs, wraps to zero on overflow
	always_ff @(posedge clk) begin
		if (anyReset)
			lifetimeCount <= LTC_ZERO;
		else if (ltcOverflow)
			lifetimeCount <= LTC_ZERO;
		else if (ltcTick)
			lifetimeCount <= lifetimeCount + LTC_ONE;
	end

	always_ff @(posedge clk) begin
		if (anyReset) begin
			uvPrev          <= 1'b0;
			undervoltageIrq <= 1'b0;
		end else begin
			uvPrev          <= uvBelow;
			undervoltageIrq <= uvBelow && !uvPrev;
		end
	end
endmodule : adm_analog_die
`default_nettype wire

// >>> design/adm_mcu_end.sv
/*
 Companion microcontroller end: AXI4-Lite slave holding control and
 status registers, drives mode writes onto the die-to-die link.
 Assumes software keeps the servicing and PLL lock duties.
*/
`timescale 1ns/1ps
`default_nettype none
module adm_mcu_end
	import adm_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	// Link
	adm_link_if.mcu          link,
	// Core stop state
	input  wire logic        coreStopped,
	// AXI4-Lite
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);
	logic        awHeld;
	logic        wHeld;
	logic [3:0]  awAddr;
	logic [31:0] wData;
	logic        doWrite;

	assign doWrite = awHeld && wHeld && !bvalid;

	always_ff @(posedge clk) begin
		if (reset) begin
			awHeld <= 1'b0;
			wHeld  <= 1'b0;
			awAddr <= REG_CTRL;
			wData  <= 32'h00000000;
		end else begin
			if (awvalid && awready) begin
				awHeld <= 1'b1;
				awAddr <= awaddr;
			end else if (doWrite)
				awHeld <= 1'b0;
			if (wvalid && wready) begin
				wHeld <= 1'b1;
				wData <= wdata;
			end else if (doWrite)
				wHeld <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			awready <= 1'b0;
			wready  <= 1'b0;
		end else begin
			awready <= !awHeld && !(awvalid && awready) && !bvalid;
			wready  <= !wHeld && !(wvalid && wready) && !bvalid;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (doWrite) begin
			bvalid <= 1'b1;
			bresp  <= (awAddr == REG_CTRL || awAddr == REG_WAKECLR) ? RESP_OKAY : RESP_SLVERR;
		end else if (bready)
			bvalid <= 1'b0;
	end

	// mode write goes onto link; clear pulse
	always_ff @(posedge clk) begin
		if (reset) begin
			link.modeWrite <= 1'b0;
			link.modeData  <= MODE_NORMAL;
			link.wakeClear <= 1'b0;
		end else begin
			link.modeWrite <= doWrite && awAddr == REG_CTRL && link.resetOutN;
			link.wakeClear <= doWrite && awAddr == REG_WAKECLR && link.resetOutN;
			if (doWrite && awAddr == REG_CTRL)
				link.modeData <= wData[1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			link.mcuStopped <= 1'b0;
		else
			link.mcuStopped <= coreStopped;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= RESP_OKAY;
		end else begin
			arready <= !rvalid && !(arvalid && arready);
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp  <= RESP_OKAY;
				unique case (araddr)
					REG_CTRL:   rdata <= {30'h0, link.modeData};
					REG_STATUS: rdata <= {13'h0, link.intermediate, link.lowPower, link.resetOutN,
						link.powerStatus};
					REG_WAKECLR: rdata <= 32'h00000000;
					default: begin
						rdata <= 32'h00000000;
						rresp <= RESP_SLVERR;
					end
				endcase
			end else if (rready)
				rvalid <= 1'b0;
		end
	end
endmodule : adm_mcu_end
`default_nettype wire

// >>> testbench/adm_link_asserts.sv
/*
 Link checker for the mode controller and microcontroller end.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module adm_link_asserts
	import adm_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// Link
	input wire logic        modeWrite,
	input wire logic [1:0]  modeData,
	input wire logic        wakeClear,
	input wire logic        mcuStopped,
	input wire logic [15:0] powerStatus,
	input wire logic        resetOutN,
	input wire logic        wakeIrq,
	input wire logic        lowPower,
	input wire logic        intermediate
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_sleep_req;
		modeWrite && modeData == MODE_SLEEP;
	endsequence
	sequence s_early_stop;
		modeWrite && modeData == MODE_STOP && !mcuStopped && !lowPower && !intermediate;
	endsequence
	a_sleep_entry: assert property (s_sleep_req |=> lowPower && !intermediate)
		else $error("Sleep request did not enter low power");
	a_stop_waits: assert property (s_early_stop |=> !lowPower)
		else $error("Stop entered before clock stopped");
	a_unused_ignored: assert property (modeWrite && modeData == MODE_UNUSED
		|=> $stable(lowPower) && $stable(intermediate))
		else $error("Unused mode code changed the mode");
	a_exit_via_inter: assert property ($fell(lowPower) && resetOutN |-> intermediate)
		else $error("Low-power exit skipped intermediate");
	a_inter_reentry: assert property (intermediate ##0 s_sleep_req |=> lowPower && !intermediate)
		else $error("Intermediate refused low-power request");
	a_normal_request: assert property (intermediate && modeWrite && modeData == MODE_NORMAL
		|=> !intermediate && !lowPower)
		else $error("Normal request did not leave intermediate");
	a_reset_holds: assert property (disable iff (1'b0) reset |=> !resetOutN)
		else $error("Reset output high during reset");
	a_cause_recorded: assert property ($rose(resetOutN) |-> powerStatus[15:8] != CAUSE_NONE)
		else $error("Reset cause not recorded");
	a_wake_flagged: assert property ($rose(wakeIrq) |-> ##[0:3] powerStatus[7:0] != WAKE_NONE)
		else $error("Wake source not flagged");
	a_irq_then_inter: assert property (wakeIrq |-> ##[0:3] intermediate)
		else $error("Wake interrupt not followed by intermediate");
	a_wake_cleared: assert property (wakeClear && !wakeIrq |-> ##[1:3] powerStatus[7:0] == WAKE_NONE)
		else $error("Wake flag not cleared");
endmodule : adm_link_asserts
`default_nettype wire

// >>> testbench/tb.sv
/*
 Self-checking bench: both ends joined by the link, driven over AXI4-Lite.
 Assumes the 100 MHz clock and a 10-cycle reset at start.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
	import adm_pkg::*;
;
	logic        clk = 1'b0, reset = 1'b1, permSupplyLow = 1'b1, extResetReq = 1'b0;
	logic        supplyBelowLow = 1'b0, supplyBelowCrank = 1'b0, crankingEnable = 1'b0;
	logic        regulatorsGood = 1'b1, extWake = 1'b0, coreStopped = 1'b0;
	logic        ltcTick = 1'b0, crankReturn = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [1:0]  bresp, rresp, rsp;
	logic        awready, wready, bvalid, arready, rvalid, watchdogInit, undervoltageIrq;
	logic        mcuSupplyRail, mcuSupplyMain, interfaceSupplyRail, useLowpowerClock, watchdogEnable;
	logic        regsReadOnly, ltcAccessible, lowvoltResetFlag;
	logic [15:0] lifetimeCount;
	int          mismatches = 0, checks_done = 0, wakeCount = 0, initCount = 0, uvCount = 0;
	always #5 clk = ~clk;
	adm_link_if link (.clk);
	adm_analog_die adm_analog_die_inst (.clk, .reset, .link, .permSupplyLow, .extResetReq, .supplyBelowLow,
		.supplyBelowCrank, .crankingEnable, .regulatorsGood, .extWake, .crankReturn, .ltcTick,
		.mcuSupplyRail, .mcuSupplyMain, .interfaceSupplyRail, .useLowpowerClock, .watchdogEnable,
		.watchdogInit, .regsReadOnly, .ltcAccessible, .undervoltageIrq, .lowvoltResetFlag, .lifetimeCount);
	adm_mcu_end adm_mcu_end_inst (.clk, .reset, .link, .coreStopped, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready);
	adm_link_asserts adm_link_asserts_inst (.clk, .reset, .modeWrite(link.modeWrite), .modeData(link.modeData),
		.wakeClear(link.wakeClear), .mcuStopped(link.mcuStopped), .powerStatus(link.powerStatus),
		.resetOutN(link.resetOutN), .wakeIrq(link.wakeIrq), .lowPower(link.lowPower),
		.intermediate(link.intermediate));
	// Pulses are counted on the falling edge, where they are settled
	always @(negedge clk) begin
		if (link.wakeIrq === 1'b1) wakeCount++;
		if (watchdogInit === 1'b1 && !reset) initCount++;
		if (undervoltageIrq === 1'b1) uvCount++;
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		logic aw, w, b;
		@(posedge clk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(negedge clk);
			aw = awready; w = wready; b = bvalid; rsp = bresp;
			@(posedge clk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end while (!b);
		bready <= 1'b0;
		chk(rsp, RESP_OKAY);
	endtask : wr
	task rdr(input logic [3:0] a);
		logic ar, rv;
		@(posedge clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(negedge clk);
			ar = arready; rv = rvalid; rd = rdata; rsp = rresp;
			@(posedge clk);
			if (ar) arvalid <= 1'b0;
		end while (!rv);
		rready <= 1'b0;
	endtask : rdr
	function automatic logic probe(input int s);
		case (s)
			0: return link.lowPower;
			1: return link.intermediate;
			default: return link.resetOutN;
		endcase
	endfunction : probe
	task waitFor(input int s, input logic v);
		for (int n = 0; n < 300 && probe(s) !== v; n++) @(negedge clk);
		chk(probe(s), v);
	endtask : waitFor
	task wakeEvent;
		@(posedge clk) regulatorsGood <= 1'b0;
		@(posedge clk) extWake <= 1'b1;
		@(posedge clk) extWake <= 1'b0;
		repeat (5) @(negedge clk);
	endtask : wakeEvent
	task t_startup;
		rdr(REG_STATUS);
		chk(rd[15:8], CAUSE_POR);
		chk(lowvoltResetFlag, 1'b1);
		chk(watchdogEnable, 1'b1);
		rdr(4'hc);
		chk(rsp, RESP_SLVERR);
		wr(REG_CTRL, {30'h0, MODE_UNUSED});
		repeat (8) @(negedge clk);
		chk({link.lowPower, link.intermediate}, 2'h0);
	endtask : t_startup
	task t_stop;
		initCount = 0;
		wr(REG_CTRL, {30'h0, MODE_STOP});
		repeat (10) @(negedge clk);
		chk({link.lowPower, regsReadOnly}, 2'h1);
		@(posedge clk) coreStopped <= 1'b1;
		waitFor(0, 1'b1);
		chk({mcuSupplyRail, mcuSupplyMain, interfaceSupplyRail}, 3'h4);
		chk({useLowpowerClock, watchdogEnable}, 2'h2);
		wakeEvent;
		chk(wakeCount, 0);
		@(posedge clk) regulatorsGood <= 1'b1;
		waitFor(1, 1'b1);
		// Pulse counters run on the same edge: let them settle
		@(negedge clk);
		chk(wakeCount, 1);
		chk(initCount, 1);
		chk({mcuSupplyMain, ltcAccessible, regsReadOnly}, 3'h5);
		@(posedge clk) coreStopped <= 1'b0;
		rdr(REG_STATUS);
		chk(rd[7:0], WAKE_EXT);
	endtask : t_stop
	task t_sleep;
		wr(REG_WAKECLR, 32'h1);
		rdr(REG_STATUS);
		chk(rd[7:0], WAKE_NONE);
		wr(REG_CTRL, {30'h0, MODE_SLEEP});
		waitFor(0, 1'b1);
		chk(link.intermediate, 1'b0);
		chk({mcuSupplyRail, interfaceSupplyRail, useLowpowerClock, watchdogEnable}, 4'h2);
		wakeEvent;
		chk(link.resetOutN, 1'b0);
		@(posedge clk) regulatorsGood <= 1'b1;
		waitFor(2, 1'b1);
		chk(link.intermediate, 1'b1);
		rdr(REG_STATUS);
		chk(rd[7:0], WAKE_EXT);
		wr(REG_CTRL, {30'h0, MODE_NORMAL});
		waitFor(1, 1'b0);
		chk({link.lowPower, regsReadOnly, useLowpowerClock, watchdogEnable}, 4'h1);
	endtask : t_sleep
	task t_uv;
		@(posedge clk) supplyBelowLow <= 1'b1;
		repeat (5) @(negedge clk);
		chk(uvCount, 1);
		@(posedge clk) supplyBelowLow <= 1'b0;
		crankingEnable <= 1'b1;
		repeat (3) @(posedge clk);
		supplyBelowLow <= 1'b1;
		repeat (5) @(negedge clk);
		chk(uvCount, 1);
		@(posedge clk) supplyBelowCrank <= 1'b1;
		repeat (5) @(negedge clk);
		chk(uvCount, 2);
		@(posedge clk) supplyBelowLow <= 1'b0;
		supplyBelowCrank <= 1'b0;
		crankingEnable <= 1'b0;
	endtask : t_uv
	task t_extreset;
		@(posedge clk) extResetReq <= 1'b1;
		repeat (3) @(negedge clk);
		chk(link.resetOutN, 1'b0);
		@(posedge clk) extResetReq <= 1'b0;
		waitFor(2, 1'b1);
		rdr(REG_STATUS);
		chk(rd[15:8], CAUSE_EXT);
		chk(rd[7:0], WAKE_NONE);
	endtask : t_extreset
	task t_ltc;
		wr(REG_CTRL, {30'h0, MODE_STOP});
		@(posedge clk) coreStopped <= 1'b1;
		waitFor(0, 1'b1);
		// full count to overflow, about 64k cycles
		@(posedge clk) ltcTick <= 1'b1;
		for (int n = 0; n < 70000 && link.intermediate !== 1'b1; n++) @(negedge clk);
		chk(link.intermediate, 1'b1);
		@(posedge clk) ltcTick <= 1'b0;
		@(negedge clk);
		chk(lifetimeCount, 16'h0002);
		chk(ltcAccessible, 1'b0);
		rdr(REG_STATUS);
		chk(rd[7:0], WAKE_LTC);
	endtask : t_ltc
	task t_crank;
		wr(REG_WAKECLR, 32'h1);
		wr(REG_CTRL, {30'h0, MODE_STOP});
		waitFor(0, 1'b1);
		@(posedge clk) crankReturn <= 1'b1;
		@(posedge clk) crankReturn <= 1'b0;
		waitFor(1, 1'b1);
		rdr(REG_STATUS);
		chk(rd[7:0], WAKE_UV);
		@(posedge clk) coreStopped <= 1'b0;
		wr(REG_CTRL, {30'h0, MODE_NORMAL});
		waitFor(1, 1'b0);
		chk(ltcAccessible, 1'b1);
	endtask : t_crank
	task end_of_test;
		if (mismatches == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		permSupplyLow <= 1'b0;
		waitFor(2, 1'b1);
		t_startup;
		t_stop;
		t_sleep;
		t_uv;
		t_extreset;
		t_ltc;
		t_crank;
		end_of_test;
	end
	// Span covers the full lifetime count plus the short scenarios
	initial begin
		repeat (90000) @(posedge clk);
		mismatches++;
		end_of_test;
	end
endmodule : tb
`default_nettype wire
